// ===== rtl/tdcs_pkg.sv
package tdcs_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] TDCS_ADDR_COUNTS = 12'h000;
  localparam logic [11:0] TDCS_ADDR_CMD = 12'h004;
  localparam logic [11:0] TDCS_ADDR_ORDER = 12'h008;
  localparam logic [11:0] TDCS_ADDR_ERR = 12'h00C;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int TDCS_ERR_SUMMARY = 0;
  localparam int TDCS_ERR_ITLV = 9;
  localparam int TDCS_ERR_OUTP = 10;
  localparam int TDCS_ERR_MEMACC = 11;
  localparam int TDCS_ERR_ITER = 14;
  localparam logic [31:0] TDCS_ERR_MASK = 32'h00004E01;
  localparam logic [31:0] TDCS_ORDER_MASK = 32'h00000003;
  localparam logic [31:0] TDCS_CMD_MASK = 32'h00000007;
  localparam logic [15:0] TDCS_CNT_MAX = 16'hFFFF;
  localparam logic [2:0] TDCS_MAP_STATE_COUNT = 3'h6;

  // ----------------------------------------
  // Commands and states
  // ----------------------------------------
  typedef enum logic [2:0] {
    TDCS_CMD_NONE = 3'h0,
    TDCS_CMD_START = 3'h1,
    TDCS_CMD_RSV2 = 3'h2,
    TDCS_CMD_RSV3 = 3'h3,
    TDCS_CMD_DBG_INIT = 3'h4,
    TDCS_CMD_DBG_STEP = 3'h5,
    TDCS_CMD_DBG_RUN = 3'h6,
    TDCS_CMD_SOFT_RST = 3'h7
  } tdcs_cmd_t;

  typedef enum logic [2:0] {
    TDCS_ST_IDLE = 3'b000,
    TDCS_ST_INIT = 3'b100,
    TDCS_ST_RUN = 3'b001,
    TDCS_ST_HALT0 = 3'b101,
    TDCS_ST_STEP = 3'b111,
    TDCS_ST_HALT6 = 3'b110,
    TDCS_ST_END = 3'b011
  } tdcs_state_t;

  // Datapath events in one bundle
  typedef struct packed {
    logic map_done;
    logic last_map;
    logic reenc_err_plain;
    logic reenc_err_itlv;
    logic mem_access;
    logic mem_access_allowed;
  } tdcs_dp_ev_t;

  // Configuration seen at start
  typedef struct packed {
    logic [4:0] min_iter;
    logic [4:0] max_iter;
    logic shared_processing;
    logic out_param_read;
    logic itlv_load;
    logic other_cfg_err;
  } tdcs_cfg_t;

  typedef struct packed {
    logic extrinsic_byte_view;
    logic interleaver_halfword_view;
  } tdcs_order_t;

endpackage

// ===== rtl/tdcs_apb_slave.sv
`timescale 1ns/1ps
module tdcs_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] rdata_in,
  input wire logic decode_ok,
  output logic wr_stb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata
);
  import tdcs_pkg::*;

  // ----------------------------------------
  // Zero wait state access phase
  // ----------------------------------------
  wire access_ph = psel && penable;
  wire setup_ph = psel && !penable;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  // Answer registered in setup so outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= setup_ph;
      pslverr_reg <= setup_ph && !decode_ok;
      prdata_reg <= (setup_ph && !pwrite && decode_ok) ? rdata_in : 32'h00000000;
    end
  end

  assign wr_stb = access_ph && pwrite && pready_reg && decode_ok;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  logic unused_ok;
  assign unused_ok = &{1'b0, pwdata[0]};
endmodule // tdcs_apb_slave

// ===== rtl/tdcs_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Upper count half: interleaved re-encode errors
// - Lower count half: plain re-encode errors
// - Command 0 idle, 1 starts decode
// - Command 4: initialize, halt in state 0
// - Command 5: one MAP, halt state 6
// - Command 6: finish remaining MAPs normally
// - Command 7: reset all but command, order
// - Reserved bits read zero, writes ignored
// - Bit 1 selects extrinsic byte view
// - Bit 0 selects halfword view, big-endian
// - Any error raises host interrupt
// - Bit 14: minimum iterations above maximum
// - Bit 11: memory accessed when forbidden
// - Bit 10: shared mode output read
// - Bit 0: summary of configuration errors
// - Bit 9: shared mode interleaver load
module tdcs_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic big_endian,
  input wire tdcs_pkg::tdcs_cfg_t cfg,
  input wire tdcs_pkg::tdcs_dp_ev_t dp_ev,
  output tdcs_pkg::tdcs_order_t order_view,
  output logic decode_go,
  output logic decode_busy,
  output logic [2:0] map_state,
  output logic err_irq
);
  import tdcs_pkg::*;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic wr_stb;
  logic [31:0] rdata_mux;
  logic [15:0] cnt_plain_reg, cnt_plain_next;
  logic [15:0] cnt_itlv_reg, cnt_itlv_next;
  logic [2:0] cmd_reg;
  logic [1:0] order_reg;
  logic [14:0] err_reg, err_next;
  tdcs_state_t state_reg, state_next;
  logic [2:0] mstate_reg, mstate_next;
  tdcs_order_t order_view_reg;
  logic irq_reg;
  logic go_reg;
  logic busy_reg;

  wire sel_counts = (paddr == TDCS_ADDR_COUNTS);
  wire sel_cmd = (paddr == TDCS_ADDR_CMD);
  wire sel_order = (paddr == TDCS_ADDR_ORDER);
  wire sel_err = (paddr == TDCS_ADDR_ERR);
  wire decode_ok = sel_counts | sel_cmd | sel_order | sel_err;

  // Command register is write only, so it reads zero
  assign rdata_mux = sel_counts ? {cnt_itlv_reg, cnt_plain_reg} :
                     sel_order ? ({30'h00000000, order_reg} & TDCS_ORDER_MASK) :
                     sel_err ? ({17'h00000, err_reg} & TDCS_ERR_MASK) :
                     32'h00000000;

  tdcs_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .rdata_in(rdata_mux),
    .decode_ok(decode_ok),
    .wr_stb(wr_stb),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata)
  );

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire [2:0] wcode = pwdata[2:0] & TDCS_CMD_MASK[2:0];
  wire cmd_wr = wr_stb && sel_cmd;
  wire do_soft = cmd_wr && (wcode == TDCS_CMD_SOFT_RST);
  wire idle_like = (state_reg == TDCS_ST_IDLE);
  wire do_start = cmd_wr && (wcode == TDCS_CMD_START) && idle_like;
  wire do_dinit = cmd_wr && (wcode == TDCS_CMD_DBG_INIT) && idle_like;
  wire halted = (state_reg == TDCS_ST_HALT0) || (state_reg == TDCS_ST_HALT6);
  wire do_step = cmd_wr && (wcode == TDCS_CMD_DBG_STEP) && halted;
  wire do_run = cmd_wr && (wcode == TDCS_CMD_DBG_RUN) && halted;
  wire any_start = do_start || do_dinit;
  wire debug_cmd = (cmd_reg >= TDCS_CMD_DBG_INIT) && (cmd_reg != TDCS_CMD_SOFT_RST);

  // ----------------------------------------
  // Decode sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    mstate_next = mstate_reg;
    case (state_reg)
      TDCS_ST_IDLE: begin
        if (do_start) begin
          state_next = TDCS_ST_RUN;
        end else if (do_dinit) begin
          state_next = TDCS_ST_INIT;
        end
      end
      TDCS_ST_INIT: begin
        state_next = TDCS_ST_HALT0;
        mstate_next = 3'h0;
      end
      TDCS_ST_HALT0, TDCS_ST_HALT6: begin
        if (do_step) begin
          state_next = TDCS_ST_STEP;
        end else if (do_run) begin
          state_next = TDCS_ST_RUN;
        end
      end
      TDCS_ST_STEP: begin
        if (dp_ev.map_done) begin
          state_next = TDCS_ST_HALT6;
          mstate_next = TDCS_MAP_STATE_COUNT;
        end
      end
      TDCS_ST_RUN: begin
        if (dp_ev.map_done && dp_ev.last_map) begin
          state_next = TDCS_ST_END;
        end
      end
      TDCS_ST_END: begin
        state_next = TDCS_ST_IDLE;
        mstate_next = 3'h0;
      end
      default: begin
        state_next = TDCS_ST_IDLE;
      end
    endcase
    if (do_soft) begin
      state_next = TDCS_ST_IDLE;
      mstate_next = 3'h0;
    end
  end

  // ----------------------------------------
  // Counters and error flags
  // ----------------------------------------
  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic ev);
    sat_inc = (ev && v != TDCS_CNT_MAX) ? v + 16'h0001 : v;
  endfunction

  // Counters restart with each new decode
  assign cnt_plain_next = (do_soft || any_start) ? 16'h0000 : sat_inc(cnt_plain_reg, dp_ev.reenc_err_plain);
  assign cnt_itlv_next = (do_soft || any_start) ? 16'h0000 : sat_inc(cnt_itlv_reg, dp_ev.reenc_err_itlv);

  wire e_iter = cfg.min_iter > cfg.max_iter;
  wire e_outp = cfg.shared_processing && cfg.out_param_read;
  wire e_itlv = cfg.shared_processing && cfg.itlv_load;
  wire cfg_bad = e_iter | e_outp | e_itlv | cfg.other_cfg_err;
  // Access allowed when mem_access_allowed is set or while halted in debug
  wire e_mem = dp_ev.mem_access && !(dp_ev.mem_access_allowed || (halted && debug_cmd));

  always_comb begin
    err_next = (do_soft || any_start) ? 15'h0000 : err_reg;
    if (any_start) begin
      err_next[TDCS_ERR_ITER] = e_iter;
      err_next[TDCS_ERR_OUTP] = e_outp;
      err_next[TDCS_ERR_ITLV] = e_itlv;
      err_next[TDCS_ERR_SUMMARY] = cfg_bad;
    end
    // Set wins over soft reset clear
    if (e_mem) begin
      err_next[TDCS_ERR_MEMACC] = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 3'h0;
      order_reg <= 2'h0;
      cnt_plain_reg <= 16'h0000;
      cnt_itlv_reg <= 16'h0000;
      err_reg <= 15'h0000;
      state_reg <= TDCS_ST_IDLE;
      mstate_reg <= 3'h0;
    end else begin
      if (cmd_wr) begin
        cmd_reg <= wcode;
      end
      if (wr_stb && sel_order) begin
        order_reg <= pwdata[1:0];
      end
      cnt_plain_reg <= cnt_plain_next;
      cnt_itlv_reg <= cnt_itlv_next;
      err_reg <= err_next;
      state_reg <= state_next;
      mstate_reg <= mstate_next;
    end
  end

  // Halfword view only meaningful in big-endian operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      order_view_reg <= '0;
      irq_reg <= 1'b0;
      go_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      order_view_reg.extrinsic_byte_view <= order_reg[1];
      order_view_reg.interleaver_halfword_view <= order_reg[0] & big_endian;
      irq_reg <= |err_next;
      go_reg <= any_start || do_step || do_run;
      // Busy taken from the next state so the pin stays a flop
      busy_reg <= (state_next != TDCS_ST_IDLE);
    end
  end

  assign order_view = order_view_reg;
  assign err_irq = irq_reg;
  assign decode_go = go_reg;
  assign decode_busy = busy_reg;
  assign map_state = mstate_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn) (|err_reg) |-> err_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq low with error set");

  property p_iter_err;
    @(posedge pclk) disable iff (!presetn) (any_start && e_iter) |=> err_reg[TDCS_ERR_ITER] && err_reg[TDCS_ERR_SUMMARY];
  endproperty
  a_iter_err: assert property (p_iter_err) else $error("iteration error not flagged");

  property p_mem_err;
    @(posedge pclk) disable iff (!presetn) e_mem |=> err_reg[TDCS_ERR_MEMACC];
  endproperty
  a_mem_err: assert property (p_mem_err) else $error("memory access error lost");

  property p_outp_err;
    @(posedge pclk) disable iff (!presetn) (any_start && e_outp) |=> err_reg[TDCS_ERR_OUTP];
  endproperty
  a_outp_err: assert property (p_outp_err) else $error("output read error missing");

  property p_itlv_err;
    @(posedge pclk) disable iff (!presetn) (any_start && e_itlv) |=> err_reg[TDCS_ERR_ITLV];
  endproperty
  a_itlv_err: assert property (p_itlv_err) else $error("interleaver load error missing");

  property p_dinit_halt;
    @(posedge pclk) disable iff (!presetn) (do_dinit && !do_soft) |=> ##1 (state_reg == TDCS_ST_HALT0 && map_state == 3'h0);
  endproperty
  a_dinit_halt: assert property (p_dinit_halt) else $error("debug init did not halt");

  property p_step_halt;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == TDCS_ST_STEP && dp_ev.map_done && !do_soft) |=> (state_reg == TDCS_ST_HALT6 && map_state == 3'h6);
  endproperty
  a_step_halt: assert property (p_step_halt) else $error("step did not halt in state 6");

  property p_soft_keep;
    @(posedge pclk) disable iff (!presetn) do_soft |=> (cmd_reg == 3'h7 && cnt_plain_reg == 16'h0000 && $stable(order_reg));
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset effect wrong");

  property p_rsv_zero;
    @(posedge pclk) disable iff (!presetn) pready && !pwrite && psel && sel_err |-> prdata[31:15] == 17'h00000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits nonzero");

  property p_ignore_dbg;
    @(posedge pclk) disable iff (!presetn) (cmd_wr && wcode == TDCS_CMD_DBG_STEP && idle_like) |=> !decode_busy;
  endproperty
  a_ignore_dbg: assert property (p_ignore_dbg) else $error("stray debug command acted");

  property p_half_view;
    @(posedge pclk) disable iff (!presetn) !big_endian |=> !order_view.interleaver_halfword_view;
  endproperty
  a_half_view: assert property (p_half_view) else $error("halfword view active in little-endian");

  property p_cnt_clear;
    @(posedge pclk) disable iff (!presetn) any_start |=> (cnt_plain_reg == 16'h0000 && cnt_itlv_reg == 16'h0000);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counts not cleared at start");

  property p_itlv_count;
    @(posedge pclk) disable iff (!presetn)
      (dp_ev.reenc_err_itlv && !do_soft && !any_start && cnt_itlv_reg != TDCS_CNT_MAX) |=>
      (cnt_itlv_reg == $past(cnt_itlv_reg) + 16'h0001);
  endproperty
  a_itlv_count: assert property (p_itlv_count) else $error("interleaved count missed an error");

  property p_go_pulse;
    @(posedge pclk) disable iff (!presetn) any_start |=> decode_go;
  endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("start not passed to datapath");

  c_start: cover property (@(posedge pclk) disable iff (!presetn) do_start);
  c_step: cover property (@(posedge pclk) disable iff (!presetn) state_reg == TDCS_ST_HALT6);
  c_end: cover property (@(posedge pclk) disable iff (!presetn) state_reg == TDCS_ST_END);
  c_soft: cover property (@(posedge pclk) disable iff (!presetn) do_soft);
endmodule // tdcs_ctrl

// ===== verification/tdcs_dp_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Decoder datapath stand-in
// ----------------------------------------
module tdcs_dp_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic decode_busy,
  input wire logic run_en,
  input wire logic inj_err,
  input wire logic mem_req,
  input wire logic mem_ok,
  output tdcs_pkg::tdcs_dp_ev_t dp_ev
);
  import tdcs_pkg::*;
  localparam int MAPS = 5;
  logic [3:0] tick_reg;
  logic [2:0] idx_reg;
  logic fire;
  // Slow on purpose: one MAP every 16 cycles
  assign fire = decode_busy && run_en && (tick_reg == 4'hF);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 4'h0;
      idx_reg <= 3'h0;
    end else begin
      tick_reg <= (decode_busy && run_en) ? tick_reg + 4'h1 : 4'h0;
      idx_reg <= !decode_busy ? 3'h0 : (fire ? idx_reg + 3'h1 : idx_reg);
    end
  end
  // Even index is the plain MAP, odd the interleaved one
  assign dp_ev.map_done = fire;
  assign dp_ev.last_map = fire && (idx_reg == 3'(MAPS - 1));
  assign dp_ev.reenc_err_plain = fire && inj_err && !idx_reg[0];
  assign dp_ev.reenc_err_itlv = fire && inj_err && idx_reg[0];
  assign dp_ev.mem_access = mem_req;
  assign dp_ev.mem_access_allowed = mem_ok;
endmodule // tdcs_dp_model

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tdcs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic big_endian = 1'b0;
  logic run_en = 1'b0;
  logic inj_err = 1'b0;
  logic mem_req = 1'b0;
  logic mem_ok = 1'b0;
  tdcs_cfg_t cfg = '0;
  tdcs_dp_ev_t dp_ev;
  tdcs_order_t order_view;
  logic pready, pslverr, decode_go, decode_busy, err_irq;
  logic [31:0] prdata, rdat;
  logic [2:0] map_state;
  logic rerr;
  int bad_count = 0;
  int checks_done = 0;

  tdcs_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .big_endian(big_endian), .cfg(cfg), .dp_ev(dp_ev), .order_view(order_view),
    .decode_go(decode_go), .decode_busy(decode_busy), .map_state(map_state), .err_irq(err_irq));
  tdcs_dp_model partner (.pclk(pclk), .presetn(presetn), .decode_busy(decode_busy), .run_en(run_en),
    .inj_err(inj_err), .mem_req(mem_req), .mem_ok(mem_ok), .dp_ev(dp_ev));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 300 && decode_busy !== lvl; i++) @(posedge pclk);
    #1;
  endtask

  task automatic mem_pulse(input logic ok);
    @(posedge pclk);
    mem_ok <= ok;
    mem_req <= 1'b1;
    @(posedge pclk);
    mem_req <= 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_map();
    apb(0, TDCS_ADDR_COUNTS, 0); chk("counts", 0, rdat);
    apb(0, TDCS_ADDR_ERR, 0); chk("errors", 0, rdat);
    apb(1, TDCS_ADDR_CMD, 32'hFFFFFFF8); chk("busy", 0, decode_busy);
    apb(0, TDCS_ADDR_CMD, 0); chk("cmd read", 0, rdat);
    apb(0, 12'h010, 0); chk("unmapped slverr", 1, rerr);
    chk("unmapped data", 0, rdat);
  endtask

  task automatic t_order();
    big_endian <= 1'b1; // Halfword view only follows bit 0 in big-endian
    apb(1, TDCS_ADDR_ORDER, 32'hFFFFFFFF);
    apb(0, TDCS_ADDR_ORDER, 0); chk("order read", 32'h3, rdat);
    chk("view both", 2'b11, order_view);
    apb(1, TDCS_ADDR_ORDER, 32'h1);
    apb(0, TDCS_ADDR_ORDER, 0); chk("view half", 2'b01, order_view);
    apb(1, TDCS_ADDR_ORDER, 32'h3); // Written while still big-endian
    big_endian <= 1'b0;
    apb(0, TDCS_ADDR_ORDER, 0); chk("view little", 2'b10, order_view);
    big_endian <= 1'b1;
  endtask

  task automatic t_bad_cfg();
    run_en <= 1'b0;
    cfg <= '{min_iter: 5'd5, max_iter: 5'd3, shared_processing: 1'b1, out_param_read: 1'b1,
      itlv_load: 1'b1, other_cfg_err: 1'b0};
    apb(1, TDCS_ADDR_CMD, 32'h1);
    apb(0, TDCS_ADDR_ERR, 0); chk("cfg errors", 32'h4601, rdat);
    chk("irq", 1, err_irq);
    apb(1, TDCS_ADDR_CMD, 32'h7);
    apb(0, TDCS_ADDR_ERR, 0); chk("errors soft", 0, rdat);
    chk("irq soft", 0, err_irq);
    chk("busy soft", 0, decode_busy);
  endtask

  task automatic t_run();
    cfg <= '{min_iter: 5'd1, max_iter: 5'd4, default: 1'b0};
    inj_err <= 1'b1;
    run_en <= 1'b1;
    apb(1, TDCS_ADDR_CMD, 32'h1);
    #1 chk("go pulse", 1, decode_go);
    @(posedge pclk);
    #1 chk("busy run", 1, decode_busy);
    chk("go drop", 0, decode_go);
    wait_busy(0);
    chk("run done", 0, decode_busy);
    apb(0, TDCS_ADDR_COUNTS, 0); chk("counts", 32'h00020003, rdat);
    apb(0, TDCS_ADDR_ERR, 0); chk("errors run", 0, rdat);
    apb(1, TDCS_ADDR_CMD, 32'h7);
    apb(0, TDCS_ADDR_COUNTS, 0); chk("counts soft", 0, rdat);
    apb(0, TDCS_ADDR_ORDER, 0); chk("order kept", 32'h3, rdat);
    inj_err <= 1'b0;
  endtask

  task automatic t_debug();
    run_en <= 1'b0;
    apb(1, TDCS_ADDR_CMD, 32'h4);
    wait_busy(1);
    repeat (4) @(posedge pclk);
    chk("halt0 busy", 1, decode_busy);
    chk("halt0 state", 0, map_state);
    mem_pulse(0); // Host looks only while halted in debug
    apb(0, TDCS_ADDR_ERR, 0); chk("debug access", 0, rdat);
    apb(1, TDCS_ADDR_CMD, 32'h5);
    run_en <= 1'b1;
    for (int i = 0; i < 100 && map_state !== 3'h6; i++) @(posedge pclk);
    run_en <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("halt6 state", 3'h6, map_state);
    chk("halt6 busy", 1, decode_busy);
    apb(1, TDCS_ADDR_CMD, 32'h6);
    run_en <= 1'b1;
    wait_busy(0);
    chk("debug run done", 0, decode_busy);
    mem_pulse(0);
    apb(0, TDCS_ADDR_ERR, 0); chk("spurious access", 32'h800, rdat);
    chk("irq access", 1, err_irq);
    apb(1, TDCS_ADDR_CMD, 32'h7);
  endtask

  task automatic t_ignored();
    logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};
    foreach (codes[i]) begin
      apb(1, TDCS_ADDR_CMD, {29'h0, codes[i]});
      repeat (3) @(posedge pclk);
      chk("ignored code", 0, decode_busy);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_order();
    t_bad_cfg();
    t_run();
    t_debug();
    t_ignored();
    print_verdict();
  end
endmodule // tb_top
